// >>> rtl/pll_cnt_pkg.sv
/*
  constants, field layout and configuration types for the clock synthesis counters.
  assumes a 32-bit classic wishbone register bus and a sampled view of the oscillator phase taps.
*/
package pll_cnt_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;    // run control
  localparam logic [7:0] STAT_OFS = 8'h04;    // status
  localparam logic [7:0] CFG_BASE = 8'h20;    // first counter, word a
  localparam logic [7:0] CFG_STRIDE = 8'h08;  // two words per counter
  localparam logic [7:0] CFG_B_OFS = 8'h04;   // word b inside a counter pair

  // control and status bits
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_LVL_LSB = 8;   // live output levels
  localparam int STAT_BAD_LSB = 16;  // per counter range faults

  // counter configuration word fields
  localparam int CW = 10;            // counter width, holds 512
  localparam int A_DIV_LSB = 0;
  localparam int A_HIGH_LSB = 16;
  localparam int A_DUTY_BIT = 31;
  localparam int B_START_LSB = 0;
  localparam int B_PHASE_LSB = 16;
  localparam int PHASE_W = 3;
  localparam int NUM_TAPS = 8;       // oscillator phase taps, 45 degrees apart

  // legal ranges, full-featured variant
  localparam logic [CW-1:0] FULL_N_MAX = 10'h200;
  localparam logic [CW-1:0] FULL_M_MAX = 10'h200;
  localparam logic [CW-1:0] FULL_C_MAX = 10'h200;
  localparam logic [CW-1:0] FULL_C_ND_MAX = 10'h100;
  localparam int FULL_NUM_POST = 6;

  // legal ranges, high-speed variant
  localparam logic [CW-1:0] FAST_N_MAX = 10'h004;
  localparam logic [CW-1:0] FAST_M_MAX = 10'h020;
  localparam logic [CW-1:0] FAST_C_MAX = 10'h020;
  localparam logic [CW-1:0] FAST_C_ND_MAX = 10'h010;
  localparam int FAST_NUM_POST = 4;

  // reset values: divide by one, square, no delay, tap zero
  localparam logic [CW-1:0] RST_DIV = 10'h001;
  localparam logic [CW-1:0] RST_HIGH = 10'h001;
  localparam logic [CW-1:0] RST_START = 10'h001;
  localparam logic [PHASE_W-1:0] RST_PHASE = 3'h0;
  localparam logic [CW-1:0] ONE = 10'h001;

  // one counter's static setup
  typedef struct packed {
    logic [CW-1:0] div;          // division value
    logic [CW-1:0] high;         // high time when not square
    logic duty50;                // square output
    logic [PHASE_W-1:0] phase;   // source tap
    logic [CW-1:0] start;        // start delay count
  } cnt_cfg_type;

endpackage : pll_cnt_pkg

// >>> rtl/pll_counter_phase_shift.sv
/*
  counter and phase selection part of a clock synthesis loop, with a wishbone register file.
  assumes the eight oscillator taps and the reference arrive as levels sampled on clk, and that
  the analog oscillator outside closes the loop from the frequency-compare pulses.
*/
// Chosen here: the address map and the Wishbone register port.
// Contract
// - oscillator equals reference times feedback over prescale
// - each output owns its post-scale divider
// - full variant: one n, one m, 1..512
// - fast variant: m 1..32, n 1..4
// - full variant: six outputs, 1..512 square
// - full variant non-square: 1..256 only
// - fast variant: four outputs, 1..32 square
// - fast variant non-square: 1..16 only
// - dedicated undivided serializer clock output
// - every counter except prescale picks any of eight taps
// - finest step is one eighth oscillator period
// - start delay C shifts by C-1 periods
// - start delay one means no shift
// - output from counted high and low times
// - delay only from taps and counts
`timescale 1ns/10ps
`default_nettype none
module pll_counter_phase_shift #(
  parameter bit FAST_VARIANT = 1'b0  // selects high-speed limits and four outputs
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pll_cnt_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [pll_cnt_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [pll_cnt_pkg::DATA_W-1:0] wb_dat_i,
  output logic [pll_cnt_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ref_in,
  input wire logic [pll_cnt_pkg::NUM_TAPS-1:0] vco_phase,
  output logic [(FAST_VARIANT ? pll_cnt_pkg::FAST_NUM_POST : pll_cnt_pkg::FULL_NUM_POST)-1:0] post_clk,
  output logic serdes_clk,
  output logic ref_div_clk,
  output logic fb_div_clk,
  output logic pfd_up,
  output logic pfd_dn
);

  localparam int CW = pll_cnt_pkg::CW;
  localparam int NUM_POST = FAST_VARIANT ? pll_cnt_pkg::FAST_NUM_POST : pll_cnt_pkg::FULL_NUM_POST;
  localparam int FB_IDX = NUM_POST;        // feedback counter slot
  localparam int PRE_IDX = NUM_POST + 1;   // prescale counter slot, exactly one of each
  localparam int NUM_CNT = NUM_POST + 2;
  localparam logic [CW-1:0] N_MAX = FAST_VARIANT ? pll_cnt_pkg::FAST_N_MAX : pll_cnt_pkg::FULL_N_MAX;
  localparam logic [CW-1:0] M_MAX = FAST_VARIANT ? pll_cnt_pkg::FAST_M_MAX : pll_cnt_pkg::FULL_M_MAX;
  localparam logic [CW-1:0] C_MAX = FAST_VARIANT ? pll_cnt_pkg::FAST_C_MAX : pll_cnt_pkg::FULL_C_MAX;
  localparam logic [CW-1:0] C_ND_MAX = FAST_VARIANT ? pll_cnt_pkg::FAST_C_ND_MAX : pll_cnt_pkg::FULL_C_ND_MAX;

  pll_cnt_pkg::cnt_cfg_type cfg_r [NUM_CNT];  // static setup per counter
  logic run_r;                                // software run request
  logic running;                              // run granted, setup legal
  logic [NUM_CNT-1:0] bad;                    // per counter range fault
  logic [NUM_CNT-1:0] cnt_out;                // divider outputs
  logic [NUM_CNT-1:0] cnt_src;                // chosen source of each divider
  logic [CW-1:0] eff_high [NUM_CNT];          // high time actually used
  logic ack_r;                                // bus answer
  logic [pll_cnt_pkg::DATA_W-1:0] dat_r;      // read data
  logic [pll_cnt_pkg::DATA_W-1:0] rd_word;    // read mux
  logic req;                                  // new request, not yet answered
  logic wr_take;                              // write commits at the acked edge
  logic ref_prev_r;                           // compare edge detect, reference side
  logic fb_prev_r;                            // compare edge detect, feedback side
  logic serdes_r;                             // registered undivided tap
  logic pfd_up_r;
  logic pfd_dn_r;
  logic tap_last_prev_r;                      // last tap sample, one eighth ahead of tap zero
  logic tap_last_rise;                        // rising edge of the last tap
  logic arm_r;                                // dividers released on a common tap edge
  logic cnt_run;                              // run as seen by the dividers
  logic [pll_cnt_pkg::DATA_W-1:0] new_a [NUM_CNT];  // word a image with a write merged in
  logic [pll_cnt_pkg::DATA_W-1:0] new_b [NUM_CNT];  // word b image with a write merged in

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  // a faulty setup stops everything rather than emit a clock of the wrong rate
  assign running = run_r & ~(|bad);

  // common release point for every divider. the last tap rises one eighth of a
  // period ahead of tap zero, so releasing on that edge makes tap zero's next
  // edge the first one any divider counts, and tap k's first counted edge then
  // lags it by k eighths. releasing on an arbitrary clock instead would let a
  // late tap count an edge of the previous period, which silently takes one
  // whole oscillator period off that output's coarse shift. the release edge
  // itself is spent in the dividers' idle step, so the last tap's own edge
  // there is skipped and its first counted edge comes one period later.
  assign tap_last_rise = vco_phase[pll_cnt_pkg::NUM_TAPS-1] & ~tap_last_prev_r;
  assign cnt_run = running & (arm_r | tap_last_rise);

  // edge detect of the last tap, and the latch that keeps the dividers released
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tap_last_prev_r <= 1'b0;
      arm_r <= 1'b0;
    end else begin
      tap_last_prev_r <= vco_phase[pll_cnt_pkg::NUM_TAPS-1];
      // stopping or a fault drops the latch, so a restart waits for a new edge
      arm_r <= running & (arm_r | tap_last_rise);
    end
  end

  // byte-lane merge of a write into a stored word
  function automatic logic [pll_cnt_pkg::DATA_W-1:0] merge(
    input logic [pll_cnt_pkg::DATA_W-1:0] old_w,
    input logic [pll_cnt_pkg::DATA_W-1:0] new_w,
    input logic [pll_cnt_pkg::SEL_W-1:0] sel
  );
    logic [pll_cnt_pkg::DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < pll_cnt_pkg::SEL_W; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // pack a setup into its word a
  function automatic logic [pll_cnt_pkg::DATA_W-1:0] word_a(input pll_cnt_pkg::cnt_cfg_type c);
    logic [pll_cnt_pkg::DATA_W-1:0] w;
    w = '0;
    w[pll_cnt_pkg::A_DIV_LSB +: CW] = c.div;
    w[pll_cnt_pkg::A_HIGH_LSB +: CW] = c.high;
    w[pll_cnt_pkg::A_DUTY_BIT] = c.duty50;
    return w;
  endfunction : word_a

  // pack a setup into its word b
  function automatic logic [pll_cnt_pkg::DATA_W-1:0] word_b(input pll_cnt_pkg::cnt_cfg_type c);
    logic [pll_cnt_pkg::DATA_W-1:0] w;
    w = '0;
    w[pll_cnt_pkg::B_START_LSB +: CW] = c.start;
    w[pll_cnt_pkg::B_PHASE_LSB +: pll_cnt_pkg::PHASE_W] = c.phase;
    return w;
  endfunction : word_b

  // bus answer: one wait state, then ack for one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // read data captured together with ack
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dat_r <= '0;
    end else if (req) begin
      dat_r <= wb_we_i ? '0 : rd_word;
    end
  end

  // read decode; unmapped offsets answer zero
  always_comb begin
    rd_word = '0;
    if (wb_adr_i == pll_cnt_pkg::CTRL_OFS) begin
      rd_word[pll_cnt_pkg::CTRL_RUN_BIT] = run_r;
    end else if (wb_adr_i == pll_cnt_pkg::STAT_OFS) begin
      rd_word[pll_cnt_pkg::STAT_RUN_BIT] = running;
      rd_word[pll_cnt_pkg::STAT_ERR_BIT] = |bad;
      rd_word[pll_cnt_pkg::STAT_LVL_LSB +: NUM_CNT] = cnt_out;
      rd_word[pll_cnt_pkg::STAT_BAD_LSB +: NUM_CNT] = bad;
    end else begin
      for (int k = 0; k < NUM_CNT; k++) begin
        if (wb_adr_i == pll_cnt_pkg::ADDR_W'(pll_cnt_pkg::CFG_BASE + k * pll_cnt_pkg::CFG_STRIDE)) begin
          rd_word = word_a(cfg_r[k]);
        end else if (wb_adr_i == pll_cnt_pkg::ADDR_W'(pll_cnt_pkg::CFG_BASE + k * pll_cnt_pkg::CFG_STRIDE
                                                      + pll_cnt_pkg::CFG_B_OFS)) begin
          rd_word = word_b(cfg_r[k]);
        end
      end
    end
  end

  // run control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_r <= 1'b0;
    end else if (wr_take && wb_adr_i == pll_cnt_pkg::CTRL_OFS && wb_sel_i[0]) begin
      run_r <= wb_dat_i[pll_cnt_pkg::CTRL_RUN_BIT];
    end
  end

  // counter setup words; meant to be written while stopped
  // a write while running is still taken, but the dividers then follow
  // the new setup from wherever they are, so phase relations are lost
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int k = 0; k < NUM_CNT; k++) begin
        cfg_r[k].div <= pll_cnt_pkg::RST_DIV;
        cfg_r[k].high <= pll_cnt_pkg::RST_HIGH;
        cfg_r[k].duty50 <= 1'b1;
        cfg_r[k].phase <= pll_cnt_pkg::RST_PHASE;
        cfg_r[k].start <= pll_cnt_pkg::RST_START;
      end
    end else if (wr_take) begin
      for (int k = 0; k < NUM_CNT; k++) begin
        if (wb_adr_i == pll_cnt_pkg::ADDR_W'(pll_cnt_pkg::CFG_BASE + k * pll_cnt_pkg::CFG_STRIDE)) begin
          cfg_r[k].div <= new_a[k][pll_cnt_pkg::A_DIV_LSB +: CW];
          cfg_r[k].high <= new_a[k][pll_cnt_pkg::A_HIGH_LSB +: CW];
          cfg_r[k].duty50 <= new_a[k][pll_cnt_pkg::A_DUTY_BIT];
        end else if (wb_adr_i == pll_cnt_pkg::ADDR_W'(pll_cnt_pkg::CFG_BASE + k * pll_cnt_pkg::CFG_STRIDE
                                                      + pll_cnt_pkg::CFG_B_OFS)) begin
          cfg_r[k].start <= new_b[k][pll_cnt_pkg::B_START_LSB +: CW];
          cfg_r[k].phase <= new_b[k][pll_cnt_pkg::B_PHASE_LSB +: pll_cnt_pkg::PHASE_W];
        end
      end
    end
  end

  // one divider per slot: post-scale outputs, then feedback, then prescale
  for (genvar k = 0; k < NUM_CNT; k++) begin : g_cnt
    // range check of this slot's setup
    always_comb begin
      bad[k] = 1'b0;
      if (cfg_r[k].div < pll_cnt_pkg::ONE || cfg_r[k].start < pll_cnt_pkg::ONE) begin
        bad[k] = 1'b1;
      end else if (k == PRE_IDX) begin
        bad[k] = cfg_r[k].div > N_MAX;
      end else if (k == FB_IDX) begin
        bad[k] = cfg_r[k].div > M_MAX;
      end else if (cfg_r[k].duty50) begin
        bad[k] = cfg_r[k].div > C_MAX;
      end else begin
        // non-square needs room for a low time and a tighter range
        bad[k] = cfg_r[k].div > C_ND_MAX || cfg_r[k].high < pll_cnt_pkg::ONE
                 || cfg_r[k].high >= cfg_r[k].div;
      end
    end

    // square setups split the count, odd counts give the extra clock to high
    assign eff_high[k] = (cfg_r[k].duty50 || k >= FB_IDX) ? CW'((cfg_r[k].div + CW'(1)) >> 1) : cfg_r[k].high;

    // this slot's two words with a pending write merged in, lane by lane;
    // only the slot whose offset matches takes them at the acked edge
    assign new_a[k] = merge(word_a(cfg_r[k]), wb_dat_i, wb_sel_i);
    assign new_b[k] = merge(word_b(cfg_r[k]), wb_dat_i, wb_sel_i);

    // prescale counts the reference; all others pick any tap
    if (k == PRE_IDX) begin : g_ref
      assign cnt_src[k] = ref_in;
    end else begin : g_tap
      assign cnt_src[k] = vco_phase[cfg_r[k].phase];
    end

    scale_counter #(
      .CW(CW)
    ) u_cnt (
      .clk(clk),
      .sys_rst(sys_rst),
      .run(cnt_run),
      .src(cnt_src[k]),
      .div(cfg_r[k].div),
      .high(eff_high[k]),
      .start(cfg_r[k].start),
      .out(cnt_out[k])
    );
  end

  // frequency compare: one pulse per divided reference and feedback edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_prev_r <= 1'b0;
      fb_prev_r <= 1'b0;
      pfd_up_r <= 1'b0;
      pfd_dn_r <= 1'b0;
    end else begin
      ref_prev_r <= cnt_out[PRE_IDX];
      fb_prev_r <= cnt_out[FB_IDX];
      // the oscillator settles where both pulse rates match: ref * m / n
      pfd_up_r <= cnt_out[PRE_IDX] & ~ref_prev_r;
      pfd_dn_r <= cnt_out[FB_IDX] & ~fb_prev_r;
    end
  end

  // undivided tap zero for the serializer, held low while stopped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serdes_r <= 1'b0;
    end else begin
      serdes_r <= running & vco_phase[0];
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign post_clk = cnt_out[NUM_POST-1:0];
  assign ref_div_clk = cnt_out[PRE_IDX];
  assign fb_div_clk = cnt_out[FB_IDX];
  assign serdes_clk = serdes_r;
  assign pfd_up = pfd_up_r;
  assign pfd_dn = pfd_dn_r;

endmodule : pll_counter_phase_shift
`default_nettype wire

// >>> rtl/scale_counter.sv
/*
  one programmable divider: start delay, then counted high and low times on edges of its source.
  assumes src is sampled on clk and that the setup inputs stay still while run is high.
*/
`timescale 1ns/10ps
`default_nettype none
module scale_counter #(
  parameter int CW = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic src,
  input wire logic [CW-1:0] div,
  input wire logic [CW-1:0] high,
  input wire logic [CW-1:0] start,
  output logic out
);

  // counter phases
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_COUNT = 3'b100
  } cnt_state_type;

  cnt_state_type state_r;       // current phase
  logic src_prev_r;             // last source sample for edge detect
  logic [CW-1:0] delay_r;       // remaining start delay
  logic [CW-1:0] pos_r;         // position inside one output period
  logic [CW-1:0] pos_nxt;       // next position, wraps at div
  logic tick;                   // rising edge of the source
  logic bypass;                 // divide by one passes the source through
  logic out_r;                  // divided output

  assign tick = src & ~src_prev_r;
  assign bypass = (div == CW'(1));
  assign pos_nxt = (pos_r == div - CW'(1)) ? '0 : pos_r + CW'(1);

  // edge detect of the chosen source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src;
    end
  end

  // phase sequence: hold, count off the start delay, then divide
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      delay_r <= '0;
      pos_r <= '0;
    end else if (!run) begin
      // stopping reloads the delay so a restart keeps the same shift
      state_r <= ST_IDLE;
      delay_r <= start;
      pos_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_r <= ST_DELAY;
        end
        ST_DELAY: begin
          if (tick) begin
            if (delay_r > CW'(1)) begin
              delay_r <= delay_r - CW'(1);
            end else begin
              state_r <= ST_COUNT;
              pos_r <= '0;
            end
          end
        end
        ST_COUNT: begin
          if (tick) begin
            pos_r <= pos_nxt;
          end
        end
      endcase
    end
  end

  // output: high for the first high counts of each period, low for the rest
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      out_r <= 1'b0;
    end else if (state_r == ST_COUNT && bypass) begin
      out_r <= src;
    end else if (state_r == ST_DELAY && tick && delay_r <= CW'(1)) begin
      out_r <= 1'b1;
    end else if (state_r == ST_COUNT && tick) begin
      out_r <= (pos_nxt < high);
    end
  end

  assign out = out_r;

endmodule : scale_counter
`default_nettype wire

// >>> verif/osc_ref_model.sv
/*
  oscillator tap and reference source feeding the counter block.
  assumes one system clock; taps are levels with an 8-clock period.
*/
`timescale 1ns/10ps
`default_nettype none
module osc_ref_model #(
  parameter int REF_P = 16  // reference period in clocks, even
) (
  input wire logic clk,
  output logic [7:0] vco_phase,
  output logic ref_in
);
  int t = 0;  // free running phase count, the oscillator never stops
  // tap k lags tap k-1 by one clock, an eighth of the period
  always @(posedge clk) begin
    t <= t + 1;
    for (int k = 0; k < 8; k++) begin
      vco_phase[k] <= ((t - k) & 7) < 4;
    end
    ref_in <= (t % REF_P) < REF_P / 2;
  end
endmodule : osc_ref_model
`default_nettype wire

// >>> verif/pll_counter_phase_shift_tb.sv
/*
  self-checking bench: registers, range faults, divided outputs, phase offset, stop.
  assumes the tap model and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pll_counter_phase_shift_tb;
  localparam int REF_P = 16;  // reference period in clocks
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] taps;
  logic ref_clk;
  logic [5:0] post;
  logic serdes;
  logic ref_div;
  logic fb_div;
  wire logic [8:0] obs = {serdes, ref_div, fb_div, post};  // slot order
  int failures = 0;
  int n_checks = 0;
  int seed = 32'h889da623;
  // per slot: div, high, square, start, tap
  int cd[9] = '{4, 4, 5, 3, 1, 1, 4, 2, 1};
  int ch[9] = '{1, 2, 1, 1, 1, 1, 1, 1, 1};
  int cq[9] = '{1, 0, 0, 1, 1, 1, 1, 1, 1};
  int cs[9] = '{1, 3, 1, 1, 1, 1, 1, 1, 1};
  int cp[9] = '{0, 3, 0, 0, 2, 0, 0, 0, 0};
  // range table: slot, div, high, square
  int tk[10] = '{0, 0, 1, 1, 2, 3, 6, 6, 7, 4};
  int td[10] = '{512, 513, 256, 257, 4, 4, 512, 513, 513, 0};
  int th[10] = '{1, 1, 255, 1, 4, 0, 1, 1, 1, 1};
  int tq[10] = '{1, 1, 0, 0, 0, 0, 1, 1, 1, 1};
  initial forever #10 clk = ~clk;
  pll_counter_phase_shift #(.FAST_VARIANT(1'b0)) i_pll_counter_phase_shift (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ref_in(ref_clk),
    .vco_phase(taps), .post_clk(post), .serdes_clk(serdes), .ref_div_clk(ref_div),
    .fb_div_clk(fb_div), .pfd_up(), .pfd_dn());
  osc_ref_model #(.REF_P(REF_P)) i_osc_ref_model (.clk(clk), .vco_phase(taps), .ref_in(ref_clk));
  // fault model: a div of zero is never legal, non-square outputs need high below div
  function automatic logic bad(int k, int d, int h, int s);
    if (d < 1) return 1'b1;
    if (k >= pll_cnt_pkg::FULL_NUM_POST || s != 0) return d > 512;
    return d > 256 || h < 1 || h >= d;
  endfunction : bad
  function automatic logic [7:0] ofs(int k);
    return pll_cnt_pkg::CFG_BASE + pll_cnt_pkg::CFG_STRIDE * 8'(k);
  endfunction : ofs
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // one classic cycle; the request stands until ack is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr
  // counts negedges while the observed bit holds v; bounded
  task automatic hold(input int b, input logic v, inout int n, inout int c);
    while (obs[b] === v && n < 900) begin
      @(negedge clk);
      n++;
      c++;
    end
    if (n >= 900) begin
      failures++;
      report_and_stop();
    end
  endtask : hold
  initial begin
    logic [31:0] q;
    int k, d, h, s, n, x, u, per, hi;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, pll_cnt_pkg::CTRL_OFS, 32'h0, 4'hf, q); `CHK(q, 32'h0)
    bus(1'b0, ofs(0), 32'h0, 4'hf, q); `CHK(q, 32'h8001_0001)
    bus(1'b0, ofs(0) + 8'h04, 32'h0, 4'hf, q); `CHK(q, 32'h0000_0001)
    wr(8'hfc, 32'hffff_ffff);
    bus(1'b0, 8'hfc, 32'h0, 4'hf, q); `CHK(q, 32'h0)
    bus(1'b1, pll_cnt_pkg::CTRL_OFS, 32'h1, 4'h0, q);
    bus(1'b0, pll_cnt_pkg::CTRL_OFS, 32'h0, 4'hf, q); `CHK(q, 32'h0)
    // table first, then random setups through the same path
    for (int i = 0; i < 18; i++) begin
      if (i < 10) begin
        k = tk[i]; d = td[i]; h = th[i]; s = tq[i];
      end else begin
        k = $random(seed) & 7; d = $random(seed) & 32'h3ff; h = $random(seed) & 32'h3ff; s = $random(seed) & 1;
      end
      wr(ofs(k), {1'(s), 5'h0, 10'(h), 6'h0, 10'(d)});
      bus(1'b0, pll_cnt_pkg::STAT_OFS, 32'h0, 4'hf, q);
      `CHK(q[1], bad(k, d, h, s))
      `CHK(q[16 + k], bad(k, d, h, s))
      wr(ofs(k), 32'h8001_0001);
    end
    wr(ofs(5) + 8'h04, 32'h0);
    bus(1'b0, pll_cnt_pkg::STAT_OFS, 32'h0, 4'hf, q); `CHK(q[1], 1'b1)
    wr(ofs(5) + 8'h04, 32'h1);
    for (k = 0; k < 8; k++) begin
      wr(ofs(k), {1'(cq[k]), 5'h0, 10'(ch[k]), 6'h0, 10'(cd[k])});
      wr(ofs(k) + 8'h04, {13'h0, 3'(cp[k]), 6'h0, 10'(cs[k])});
    end
    wr(pll_cnt_pkg::CTRL_OFS, 32'h1);
    bus(1'b0, pll_cnt_pkg::STAT_OFS, 32'h0, 4'hf, q); `CHK(q[1:0], 2'b01)
    repeat (100) @(negedge clk);
    // period and high time per output; the prescale slot counts reference clocks
    for (k = 0; k < 9; k++) begin
      n = 0; x = 0; hi = 0;
      u = (k == 7) ? REF_P : 8;
      hold(k, 1'b1, n, x);
      hold(k, 1'b0, n, x);
      hold(k, 1'b1, n, hi);
      per = hi;
      hold(k, 1'b0, n, per);
      `CHK(per, cd[k] * u)
      `CHK(hi, (cd[k] == 1) ? u / 2 : ((cq[k] != 0) ? (cd[k] + 1) / 2 : ch[k]) * u)
    end
    // offset from a rise of output 0 to the next rise of output 1, inside one period
    n = 0; x = 0; per = 0;
    hold(0, 1'b1, n, x);
    hold(0, 1'b0, n, x);
    hold(1, 1'b1, n, per);
    hold(1, 1'b0, n, per);
    `CHK(per, (cp[1] - cp[0]) + (cs[1] - cs[0]) * 8)
    wr(pll_cnt_pkg::CTRL_OFS, 32'h0);
    repeat (2) @(negedge clk);
    `CHK(obs, 9'h000)
    report_and_stop();
  end
endmodule : pll_counter_phase_shift_tb
`default_nettype wire

// >>> verif/pll_cps_checker.sv
/*
  port checker for the counter block: bus answer, compare pulses, serializer tap, reset.
  assumes it is bound to every instance of the block and sees its ports only.
*/
`timescale 1ns/10ps
`default_nettype none
module pll_cps_checker #(
  parameter bit FAST_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [pll_cnt_pkg::NUM_TAPS-1:0] vco_phase,
  input wire logic [(FAST_VARIANT ? pll_cnt_pkg::FAST_NUM_POST : pll_cnt_pkg::FULL_NUM_POST)-1:0] post_clk,
  input wire logic serdes_clk,
  input wire logic ref_div_clk,
  input wire logic fb_div_clk,
  input wire logic pfd_up,
  input wire logic pfd_dn
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  up_on_rise_a: assert property ($rose(ref_div_clk) |=> pfd_up)
    else $error("no up pulse after prescale edge");
  dn_on_rise_a: assert property ($rose(fb_div_clk) |=> pfd_dn)
    else $error("no down pulse after feedback edge");
  up_cause_a: assert property (pfd_up |-> $past(ref_div_clk) && !$past(ref_div_clk, 2))
    else $error("up pulse without prescale edge");
  serdes_tap_a: assert property (serdes_clk |-> $past(vco_phase[0]))
    else $error("serializer clock not from tap zero");
  // reset itself is the antecedent here, so this one is never disabled
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> post_clk == '0 && !serdes_clk && !pfd_up && !wb_ack_o)
    else $error("outputs active after reset");
  cover property (wb_cyc_i && wb_ack_o);
  cover property ($rose(post_clk[0]));
  cover property (pfd_up && pfd_dn);
endmodule : pll_cps_checker
bind pll_counter_phase_shift pll_cps_checker #(.FAST_VARIANT(FAST_VARIANT)) i_pll_cps_checker (
  .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .vco_phase(vco_phase), .post_clk(post_clk), .serdes_clk(serdes_clk), .ref_div_clk(ref_div_clk),
  .fb_div_clk(fb_div_clk), .pfd_up(pfd_up), .pfd_dn(pfd_dn));
`default_nettype wire
